/* pthb_pkg.sv */
// Purpose: shared constants for the proximity threshold bank
// Assumes: byte-wide register port, register index equals printed address
// Notes: the compressed-format expansion is the only shared function
package pthb_pkg;
   localparam int PTHB_CHANNELS = 3;
   localparam int PTHB_THR_W = 16;
   localparam int PTHB_BYTE_W = 8;
   localparam int PTHB_ADDR_W = 8;
   // register addresses, channel 1 in entry 0
   localparam logic [2:0][7:0] PTHB_LOW_ADDR = {8'h15, 8'h13, 8'h11};
   localparam logic [2:0][7:0] PTHB_HIGH_ADDR = {8'h16, 8'h14, 8'h12};
   localparam logic [7:0] PTHB_LOW_RESET = 8'h00;
   localparam logic [7:0] PTHB_HIGH_RESET = 8'h00;
   localparam logic [7:0] PTHB_UNMAPPED_DATA = 8'h00;
   localparam logic [15:0] PTHB_THR_SAT = 16'hFFFF;
   localparam logic [3:0] PTHB_EXP_ZERO = 4'h0;

   // compressed byte: upper nibble exponent, lower nibble mantissa
   function automatic logic [15:0] pthb_expand(input logic [7:0] code);
      logic [31:0] wide;
      wide = 32'h0000_0000;
      if (code[7:4] == PTHB_EXP_ZERO) begin
         wide = {28'h000_0000, code[3:0]};
      end else begin
         wide = {27'h000_0000, 1'b1, code[3:0]} << code[7:4];
      end
      // saturate instead of wrapping, so a large code never reads as small
      if (wide[31:16] != 16'h0000) begin
         return PTHB_THR_SAT;
      end
      return wide[15:0];
   endfunction : pthb_expand
endpackage : pthb_pkg

/* pthb_chan_cmp.sv */
// Purpose: one channel's threshold comparison
// Assumes: measurement strobe and data come from logic on clk_sys
// Notes: the hit flag is a registered one-cycle pulse
`timescale 1ns/1ns
module pthb_chan_cmp #(
   parameter int W = 16
) (
   input wire logic clk_sys, // system clock
   input wire logic sys_rst, // synchronous reset, high
   input wire logic meas_valid, // measurement strobe
   input wire logic [W-1:0] meas, // measurement value
   input wire logic [W-1:0] threshold, // live threshold
   output logic hit // measurement above threshold
);
   // threshold is sampled live; a half-written pair is used as it stands
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         hit <= 1'b0;
      end else begin
         hit <= meas_valid && (meas > threshold);
      end
   end
endmodule : pthb_chan_cmp

/* pthb_bank.sv */
// Purpose: proximity threshold register bank with per-channel compare
// Assumes: register front end and sequencer share clk_sys
// Notes: no shadowing of byte pairs; the host must pause measurements
`timescale 1ns/1ns
module pthb_bank (
   input wire logic clk_sys, // system clock, 250 MHz
   input wire logic sys_rst, // synchronous reset, high
   input wire logic reg_wr, // register write strobe
   input wire logic reg_rd, // register read strobe
   input wire logic [7:0] reg_addr, // register address
   input wire logic [7:0] reg_wdata, // write data
   output logic [7:0] reg_rdata, // read data, one cycle after reg_rd
   output logic reg_rvalid, // read data valid pulse
   input wire logic legacy_compressed, // older-revision threshold format
   input wire logic prox1_meas_valid, // channel 1 measurement strobe
   input wire logic [15:0] prox1_measurement, // channel 1 measurement
   input wire logic prox2_meas_valid, // channel 2 measurement strobe
   input wire logic [15:0] prox2_measurement, // channel 2 measurement
   input wire logic prox3_meas_valid, // channel 3 measurement strobe
   input wire logic [15:0] prox3_measurement, // channel 3 measurement
   output logic [15:0] prox1_threshold, // channel 1 effective threshold
   output logic [15:0] prox2_threshold, // channel 2 effective threshold
   output logic [15:0] prox3_threshold, // channel 3 effective threshold
   output logic [2:0] prox_hit // per-channel interrupt request pulse
);
   localparam int NCH = pthb_pkg::PTHB_CHANNELS;
   localparam int TW = pthb_pkg::PTHB_THR_W;

   // packed per-channel bytes so the generate loop indexes them directly
   logic [NCH-1:0][7:0] thr_low;
   logic [NCH-1:0][7:0] thr_high;
   logic [NCH-1:0][TW-1:0] thr_eff;
   logic [NCH-1:0][TW-1:0] meas_arr;
   logic [NCH-1:0] meas_vld;
   // read mux result, captured only on a read strobe
   logic [7:0] next_rdata;

   // gather the channel ports so one loop serves all channels
   assign meas_arr = {prox3_measurement, prox2_measurement, prox1_measurement};
   assign meas_vld = {prox3_meas_valid, prox2_meas_valid, prox1_meas_valid};

   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_chan
         // low byte storage, also the compressed byte in legacy mode
         always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
               thr_low[gi] <= pthb_pkg::PTHB_LOW_RESET;
            end else if (reg_wr &&
                         reg_addr == pthb_pkg::PTHB_LOW_ADDR[gi]) begin
               thr_low[gi] <= reg_wdata;
            end
         end

         // high byte storage
         always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
               thr_high[gi] <= pthb_pkg::PTHB_HIGH_RESET;
            end else if (reg_wr &&
                         reg_addr == pthb_pkg::PTHB_HIGH_ADDR[gi]) begin
               thr_high[gi] <= reg_wdata;
            end
         end

         // effective threshold; the high byte is ignored in legacy mode
         always_comb begin
            if (legacy_compressed) begin
               thr_eff[gi] = pthb_pkg::pthb_expand(thr_low[gi]);
            end else begin
               thr_eff[gi] = {thr_high[gi], thr_low[gi]};
            end
         end

         pthb_chan_cmp #(
            .W(TW)
         ) u_cmp (
            .clk_sys(clk_sys),
            .sys_rst(sys_rst),
            .meas_valid(meas_vld[gi]),
            .meas(meas_arr[gi]),
            .threshold(thr_eff[gi]),
            .hit(prox_hit[gi])
         );
      end
   endgenerate

   assign prox1_threshold = thr_eff[0];
   assign prox2_threshold = thr_eff[1];
   assign prox3_threshold = thr_eff[2];

   // read decode; unmapped addresses read as zero
   always_comb begin
      next_rdata = pthb_pkg::PTHB_UNMAPPED_DATA;
      for (int i = 0; i < NCH; i++) begin
         if (reg_addr == pthb_pkg::PTHB_LOW_ADDR[i]) begin
            next_rdata = thr_low[i];
         end
         if (reg_addr == pthb_pkg::PTHB_HIGH_ADDR[i]) begin
            next_rdata = thr_high[i];
         end
      end
   end

   // registered read data keeps the output glitch free
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         reg_rdata <= pthb_pkg::PTHB_UNMAPPED_DATA;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   // one clock for every check; reset cycles are not judged
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   a_ch2_low_write: assert property (
      reg_wr && reg_addr == 8'h13 |=> thr_low[1] == $past(reg_wdata))
      else $error("channel 2 low byte not stored");
   a_ch2_high_read: assert property (
      reg_wr && reg_addr == 8'h14 ##1 !reg_wr ##1
      reg_rd && reg_addr == 8'h14 && !reg_wr |=>
      reg_rdata == $past(reg_wdata, 3))
      else $error("channel 2 high byte readback wrong");
   a_ch1_high_read: assert property (
      reg_rd && reg_addr == 8'h12 |=> reg_rvalid
      && reg_rdata == $past(thr_high[0]))
      else $error("channel 1 high byte read wrong");
   a_ch3_low_read: assert property (
      reg_rd && reg_addr == 8'h15 |=> reg_rdata == $past(thr_low[2]))
      else $error("channel 3 low byte read wrong");
   a_cmp_hit: assert property (
      prox2_meas_valid |=> prox_hit[1] ==
      ($past(prox2_measurement) > $past(thr_eff[1])))
      else $error("channel 2 compare result wrong");
   a_no_meas_hit: assert property (
      !prox1_meas_valid |=> !prox_hit[0])
      else $error("hit without measurement");
   a_mixed_half: assert property (
      !legacy_compressed && reg_wr && reg_addr == 8'h13 ##1
      !legacy_compressed |-> prox2_threshold ==
      {$past(thr_high[1]), $past(reg_wdata)})
      else $error("half-written threshold not applied live");
   a_legacy_fmt: assert property (
      legacy_compressed |->
      prox3_threshold == pthb_pkg::pthb_expand(thr_low[2]))
      else $error("legacy threshold not expanded from low byte");
   a_reset_low: assert property (@(posedge clk_sys)
      $past(sys_rst) |-> thr_low == '0 && reg_rdata == 8'h00)
      else $error("low bytes not cleared by reset");
   a_ch1_low_write: assert property (
      reg_wr && reg_addr == 8'h11 |=> thr_low[0] == $past(reg_wdata))
      else $error("channel 1 low byte not stored");
   a_ch3_high_write: assert property (
      reg_wr && reg_addr == 8'h16 |=> thr_high[2] == $past(reg_wdata))
      else $error("channel 3 high byte not stored");
   a_concat_thr: assert property (
      !legacy_compressed |-> prox1_threshold == {thr_high[0], thr_low[0]})
      else $error("threshold not high over low");

   // remaining map, compare, format and read-strobe checks
   a_ch2_high_write: assert property (
      reg_wr && reg_addr == 8'h14 |=> thr_high[1] == $past(reg_wdata))
      else $error("channel 2 high byte not stored");
   a_ch2_low_read: assert property (
      reg_rd && reg_addr == 8'h13 |=> reg_rdata == $past(thr_low[1]))
      else $error("channel 2 low byte read wrong");
   a_ch1_high_write: assert property (
      reg_wr && reg_addr == 8'h12 |=> thr_high[0] == $past(reg_wdata))
      else $error("channel 1 high byte not stored");
   a_ch3_low_write: assert property (
      reg_wr && reg_addr == 8'h15 |=> thr_low[2] == $past(reg_wdata))
      else $error("channel 3 low byte not stored");
   a_ch1_hit: assert property (
      prox1_meas_valid |=> prox_hit[0] ==
      ($past(prox1_measurement) > $past(thr_eff[0])))
      else $error("channel 1 compare result wrong");
   a_ch3_hit: assert property (
      prox3_meas_valid |=> prox_hit[2] ==
      ($past(prox3_measurement) > $past(thr_eff[2])))
      else $error("channel 3 compare result wrong");
   a_rvalid_pulse: assert property (
      reg_rd |=> reg_rvalid)
      else $error("read strobe without valid pulse");
   a_rvalid_idle: assert property (
      !reg_rd |=> !reg_rvalid)
      else $error("valid pulse without read strobe");
   a_ch1_low_read: assert property (
      reg_rd && reg_addr == 8'h11 |=> reg_rdata == $past(thr_low[0]))
      else $error("channel 1 low byte read wrong");
   a_ch3_high_read: assert property (
      reg_rd && reg_addr == 8'h16 |=> reg_rdata == $past(thr_high[2]))
      else $error("channel 3 high byte read wrong");
   a_concat_ch3: assert property (
      !legacy_compressed |-> prox3_threshold == {thr_high[2], thr_low[2]})
      else $error("channel 3 threshold not high over low");
   a_legacy_ch1: assert property (
      legacy_compressed |->
      prox1_threshold == pthb_pkg::pthb_expand(thr_low[0]))
      else $error("channel 1 legacy threshold not expanded");

   c_full_update: cover property (
      reg_wr && reg_addr == 8'h13 ##1 reg_wr && reg_addr == 8'h14);
   c_hit_ch3: cover property (prox3_meas_valid ##1 prox_hit[2]);
   c_legacy_hit: cover property (legacy_compressed && prox_hit[0]);
   // a byte read straight back, and a channel 2 hit outside legacy mode
   c_wr_then_rd: cover property (
      reg_wr && reg_addr == 8'h14 ##2 reg_rd && reg_addr == 8'h14);
   c_mixed_hit: cover property (!legacy_compressed && prox_hit[1]);
endmodule : pthb_bank

/* pthb_host.sv */
// Purpose: host model driving the byte register port
// Assumes: strobes change 1 ns after a rising edge of clk_sys
// Notes: idle address lines show the inverse of the last value; a read leaves write data as it was
`timescale 1ns/1ns
module pthb_host (
   input wire logic clk_sys, // system clock
   output logic reg_wr, // write strobe
   output logic reg_rd, // read strobe
   output logic [7:0] reg_addr, // register address
   output logic [7:0] reg_wdata, // write data
   input wire logic [7:0] reg_rdata, // read data
   input wire logic reg_rvalid // read data valid
);
   // quiet port at time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // one byte write; bench keeps measurements idle meanwhile
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk_sys);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr
   // one byte read; answer is registered at the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic v);
      @(posedge clk_sys);
      #1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clk_sys);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      v = reg_rvalid;
      d = reg_rdata;
   endtask : rd
endmodule : pthb_host

/* tb_top.sv */
// Purpose: self-checking bench for the proximity threshold bank
// Assumes: host model owns the register port, bench owns measurements
// Notes: measurements never overlap register updates
`timescale 1ns/1ns
module tb_top;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic reg_wr, reg_rd, reg_rvalid, v;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
   logic legacy_compressed = 1'b0;
   logic [2:0] mv = 3'h0;
   logic [15:0] m1 = 16'h0000, m2 = 16'h0000, m3 = 16'h0000;
   logic [15:0] t1, t2, t3;
   logic [2:0] prox_hit;
   logic [7:0] codes [4] = '{8'h00, 8'h05, 8'hF0, 8'h34};
   logic [15:0] exps [4] = '{16'h0000, 16'h0005, 16'hFFFF, 16'h00A0};
   int error_cnt = 0;
   int num_checks = 0;
   // 4 ns period
   always #2 clk_sys = ~clk_sys;
   pthb_host host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid));
   pthb_bank uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .legacy_compressed(legacy_compressed), .prox1_meas_valid(mv[0]),
      .prox1_measurement(m1), .prox2_meas_valid(mv[1]),
      .prox2_measurement(m2), .prox3_meas_valid(mv[2]),
      .prox3_measurement(m3), .prox1_threshold(t1), .prox2_threshold(t2),
      .prox3_threshold(t3), .prox_hit(prox_hit));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic results();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results
   // read must answer with a valid pulse and the expected byte
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      host.rd(a, rd, v);
      chk({15'h0000, v}, 16'h0001);
      chk({8'h00, rd}, {8'h00, exp});
   endtask : rdchk
   // all three channels strobed together; hit lands one cycle later
   task automatic measure(input logic [15:0] a, b, c, input logic [2:0] e);
      @(posedge clk_sys);
      #1;
      mv = 3'h7;
      m1 = a;
      m2 = b;
      m3 = c;
      @(posedge clk_sys);
      #1;
      mv = 3'h0;
      chk({13'h0000, prox_hit}, {13'h0000, e});
   endtask : measure
   // watchdog, far beyond the hundred or so cycles the tests need
   initial begin
      #20000;
      error_cnt++;
      results();
   end
   // main sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      #1;
      sys_rst = 1'b0;
      for (int i = 16; i <= 23; i++) begin
         rdchk(8'(i), 8'h00);
      end
      for (int i = 1; i <= 7; i++) begin
         host.wr(8'(8'h10 + i), 8'(i * 8'h21));
      end
      for (int i = 1; i <= 6; i++) begin
         rdchk(8'(16 + i), 8'(33 * i));
      end
      rdchk(8'h17, 8'h00);
      chk(t1, 16'h4221);
      chk(t2, 16'h8463);
      chk(t3, 16'hC6A5);
      // strict greater-than, so equal values must not hit
      measure(16'h4222, 16'h8463, 16'hC6A4, 3'h1);
      measure(16'h4221, 16'h8464, 16'hFFFF, 3'h6);
      // lone low byte gives a mixed threshold
      host.wr(8'h13, 8'h00);
      chk(t2, 16'h8400);
      measure(16'h0000, 16'h8401, 16'h0000, 3'h2);
      // high byte completes the pair and is read straight back
      host.wr(8'h14, 8'h5A);
      rdchk(8'h14, 8'h5A);
      chk(t2, 16'h5A00);
      legacy_compressed = 1'b1;
      for (int k = 0; k < 4; k++) begin
         host.wr(8'h11, codes[k]);
         host.wr(8'h13, codes[k]);
         host.wr(8'h15, codes[k]);
         chk(t1, exps[k]);
         chk(t2, exps[k]);
         chk(t3, exps[k]);
      end
      measure(16'h00A1, 16'h00A0, 16'h00A1, 3'h5);
      // second reset in mid-run
      sys_rst = 1'b1;
      @(posedge clk_sys);
      #1;
      sys_rst = 1'b0;
      rdchk(8'h13, 8'h00);
      chk(t2, 16'h0000);
      results();
   end
endmodule : tb_top
